//--- rtl/scan_defs.svh
// constants and functional notes for the simultaneous scan channel list
// Functional notes
// - large build has analog channels 0 to 11
// - small build has analog channels 0 to 5
// - one snapshot per tick, list order irrelevant
// - list holds 23 entries, or 17 small
// - channel 12 or 6 returns digital port
// - 32-bit value split low then high
// - counter halves at 13-16, or 7-10
// - decoder halves at 17-22, or 11-16
// - non-analog entries follow the analog path; code accepts them anywhere in the list
// - one input range for whole subsystem
// - gain fixed at one, not settable
// - internal pacing 0.75 S/s to 225 kS/s
// - external pacing on falling clock edge
// - external rate equals applied clock rate
// - same tick paces digital, counter, decoder
// - trigger and each tick capture everything
// - offset binary codes, clipped at limits
// - results fixed at sixteen bits
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH
`define A_CTRL 8'h00
`define A_PERIOD 8'h04
`define A_LADD 8'h08
`define A_LCLR 8'h0c
`define A_STAT 8'h10
`define A_INFO 8'h14
`define B_RUN 0
`define B_EXT 1
`define B_RNG5 2
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`define NAIN_L 5'h0c
`define NAIN_S 5'h06
`define DIG_L 5'h0c
`define DIG_S 5'h06
`define PAIR_L 5'h0d
`define PAIR_S 5'h07
`define NCH_L 5'h17
`define NCH_S 5'h11
`define LIST_DEPTH 5'h17
`define GAIN 8'h01
`define RES_BITS 8'h10
`define CLK_HZ 64'h0000_0000_05f5_e100
`define MAX_RATE_SPS 64'h0000_0000_0003_6ee8
`define MIN_RATE_MSPS 64'h0000_0000_0000_02ee
`define MSPS_SCALE 64'h0000_0000_0000_03e8
`define PER_MIN 32'((`CLK_HZ + `MAX_RATE_SPS - 64'h1) / `MAX_RATE_SPS)
`define PER_MAX_DEF 32'((`CLK_HZ * `MSPS_SCALE) / `MIN_RATE_MSPS)
`define CLIP_HI 18'sh07fff
`define CLIP_LO 18'sh38000
`define OB_FLIP 16'h8000
`define CODE_FS 16'hffff
`define CODE_ZS 16'h0000
`endif

//--- rtl/scan_pkg.sv
// types shared by the scan list controller and its list memory
package scan_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_SEND  = 3'h4
  } sweep_st_t;

  typedef struct packed {
    logic [11:0][15:0] ain;
    logic [15:0]       dig;
    logic [4:0][31:0]  pair;
  } snap_t;

  typedef struct packed {
    logic [22:0][4:0] word;
    logic [4:0]       rdata;
  } mem_t;

  typedef struct packed {
    sweep_st_t  fsm;
    logic       awready;
    logic       wready;
    logic       arready;
    logic       aw_got;
    logic [7:0] awaddr;
    logic       w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic       run;
    logic       ext;
    logic       rng5;
    logic [31:0] period;
    logic [31:0] div;
    logic [4:0] len;
    logic [31:0] used;
    logic       err;
    logic [2:0] xs;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [4:0] idx;
    snap_t      snap;
    logic       conv_start;
    logic [15:0] ticks;
    logic       word_valid;
    logic [15:0] word_data;
    logic [4:0] word_entry;
    logic       word_last;
  } ctl_t;
endpackage

//--- rtl/list_mem_if.sv
// write and read port between the controller and the list memory
`timescale 1ns/1ps
`default_nettype none
interface list_mem_if;
  logic       we;
  logic [4:0] waddr;
  logic [4:0] wdata;
  logic [4:0] raddr;
  logic [4:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- rtl/list_mem.sv
// channel list storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "scan_defs.svh"
module list_mem
  import scan_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  list_mem_if.mem  port
);
  mem_t m_q;
  mem_t m_d;

  always_comb begin
    m_d = m_q;
    if (port.we && port.waddr < `LIST_DEPTH) begin
      m_d.word[port.waddr] = port.wdata;
    end
    m_d.rdata = (port.raddr < `LIST_DEPTH) ? m_q.word[port.raddr] : 5'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign port.rdata = m_q.rdata;
endmodule
`default_nettype wire

//--- rtl/scan_list_ctrl.sv
// scan list controller: register slave, sample pacing, snapshot and word stream
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "scan_defs.svh"
module scan_list_ctrl
  import scan_pkg::*;
#(
  parameter bit          LARGE   = 1'b1,
  parameter logic [31:0] PER_MAX = `PER_MAX_DEF
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [7:0]          araddr,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  input  wire logic [11:0][17:0]   ain_raw,
  input  wire logic [15:0]         din,
  input  wire logic                ext_clk,
  input  wire logic [4:0][31:0]    pair_in,
  output logic                     conv_start,
  output logic                     range_5v,
  output logic                     word_valid,
  output logic [15:0]              word_data,
  output logic [4:0]               word_entry,
  output logic                     word_last
);
  localparam logic [4:0] NAIN  = LARGE ? `NAIN_L : `NAIN_S;
  localparam logic [4:0] DIG   = LARGE ? `DIG_L : `DIG_S;
  localparam logic [4:0] PBASE = LARGE ? `PAIR_L : `PAIR_S;
  localparam logic [4:0] NCH   = LARGE ? `NCH_L : `NCH_S;
  localparam logic [31:0] PMIN = `PER_MIN;

  ctl_t s_q;
  ctl_t s_d;
  logic mem_we;
  list_mem_if mif ();

  list_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port    (mif)
  );

  // offset binary with clipping at both ends
  function automatic logic [15:0] clip(input logic signed [17:0] r);
    if (r > `CLIP_HI) return `CODE_FS;
    if (r < `CLIP_LO) return `CODE_ZS;
    return r[15:0] ^ `OB_FLIP;
  endfunction

  // every entry reads the same snapshot
  function automatic logic [15:0] pick(input snap_t s, input logic [4:0] ch);
    logic [4:0] k;
    k = 5'(ch - PBASE);
    if (ch < NAIN) return s.ain[ch[3:0]];
    if (ch == DIG) return s.dig;
    return k[0] ? s.pair[k[3:1]][31:16] : s.pair[k[3:1]][15:0];
  endfunction

  // halves must be listed together before a start
  function automatic logic pairs_ok(input logic [31:0] u);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (u[int'(PBASE) + 2 * k] != u[int'(PBASE) + 2 * k + 1]) ok = 1'b0;
    end
    return ok;
  endfunction

  always_comb begin
    logic        tick;
    logic        we_c;
    logic [31:0] mask;
    logic [31:0] cv;
    logic [31:0] pv;
    logic [4:0]  ch;
    tick = 1'b0;
    we_c = 1'b0;
    mask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    cv   = '0;
    pv   = '0;
    ch   = s_q.wdata[4:0];
    s_d  = s_q;
    s_d.word_valid = 1'b0;
    s_d.conv_start = 1'b0;
    s_d.d1 = din;
    s_d.d2 = s_q.d1;
    s_d.xs = {s_q.xs[1:0], ext_clk};

    // sample pacing; external edges count only after two sync stages
    if (s_q.run) begin
      if (s_q.ext) begin
        // one tick per falling edge, no division
        if (s_q.xs[2] && !s_q.xs[1]) tick = 1'b1;
      end else if (s_q.div == '0) begin
        tick = 1'b1;
        s_d.div = s_q.period - 32'h1;
      end else begin
        s_d.div = s_q.div - 32'h1;
      end
    end

    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (bready && s_q.bvalid) s_d.bvalid = 1'b0;

    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `RESP_OK;
      case ({s_q.awaddr[7:2], 2'h0})
        `A_CTRL: begin
          cv = ({29'h0, s_q.rng5, s_q.ext, s_q.run} & ~mask) | (s_q.wdata & mask);
          s_d.ext  = cv[`B_EXT];
          // one range bit for the whole subsystem
          s_d.rng5 = cv[`B_RNG5];
          if (cv[`B_RUN] && !s_q.run) begin
            // refuse unpaired, empty or mid-sweep; else trigger now
            if (pairs_ok(s_q.used) && s_q.len != 5'h00 && s_q.fsm == ST_IDLE) begin
              s_d.run = 1'b1;
              tick    = 1'b1;
              s_d.div = s_q.period - 32'h1;
            end else begin
              s_d.err = 1'b1;
            end
          end else if (!cv[`B_RUN]) begin
            s_d.run = 1'b0;
          end
        end
        `A_PERIOD: begin
          pv = (s_q.period & ~mask) | (s_q.wdata & mask);
          // clamp to the supported rate window
          if (pv < PMIN) pv = PMIN;
          if (pv > PER_MAX) pv = PER_MAX;
          s_d.period = pv;
        end
        `A_LADD: begin
          if (s_q.wstrb[0]) begin
            // reject duplicates, unknown channels and overflow
            if (s_q.run || s_q.fsm != ST_IDLE || ch >= NCH || s_q.used[ch] || s_q.len >= NCH) begin
              s_d.err = 1'b1;
            end else begin
              we_c = 1'b1;
              s_d.used[ch] = 1'b1;
              s_d.len = s_q.len + 5'h01;
            end
          end
        end
        `A_LCLR: begin
          if (!s_q.run && s_q.fsm == ST_IDLE) begin
            s_d.len  = 5'h00;
            s_d.used = '0;
            s_d.err  = 1'b0;
          end
        end
        default: s_d.bresp = `RESP_ERR;
      endcase
    end

    if (rready && s_q.rvalid) s_d.rvalid = 1'b0;
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `RESP_OK;
      case ({araddr[7:2], 2'h0})
        `A_CTRL:   s_d.rdata = {29'h0, s_q.rng5, s_q.ext, s_q.run};
        `A_PERIOD: s_d.rdata = s_q.period;
        `A_LADD:   s_d.rdata = {27'h0, s_q.len};
        `A_LCLR:   s_d.rdata = '0;
        `A_STAT:   s_d.rdata = {s_q.ticks, 13'h0, s_q.fsm != ST_IDLE, s_q.err, s_q.run};
        // gain and resolution are read-only constants
        `A_INFO:   s_d.rdata = {`GAIN, `RES_BITS, 3'h0, NCH, 7'h0, LARGE};
        default: begin
          s_d.rdata = '0;
          s_d.rresp = `RESP_ERR;
        end
      endcase
    end

    unique case (s_q.fsm)
      ST_IDLE: begin
        // one capture of every source per tick
        if (tick) begin
          for (int i = 0; i < 12; i++) s_d.snap.ain[i] = clip(ain_raw[i]);
          s_d.snap.dig   = s_q.d2;
          s_d.snap.pair  = pair_in;
          s_d.conv_start = 1'b1;
          s_d.ticks      = s_q.ticks + 16'h0001;
          s_d.idx        = 5'h00;
          s_d.fsm        = ST_FETCH;
        end
      end
      ST_FETCH: s_d.fsm = ST_SEND;
      ST_SEND: begin
        // one word per entry, in list order
        s_d.word_valid = 1'b1;
        s_d.word_data  = pick(s_q.snap, mif.rdata);
        s_d.word_entry = s_q.idx;
        s_d.word_last  = (s_q.idx == s_q.len - 5'h01);
        if (s_q.idx == s_q.len - 5'h01) begin
          s_d.fsm = ST_IDLE;
        end else begin
          s_d.idx = s_q.idx + 5'h01;
          s_d.fsm = ST_FETCH;
        end
      end
    endcase

    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
    mem_we = we_c;
  end

  assign mif.we    = mem_we;
  assign mif.waddr = s_q.len;
  assign mif.wdata = s_q.wdata[4:0];
  assign mif.raddr = s_q.idx;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.fsm     <= ST_IDLE;
      s_q.period  <= PMIN;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready    = s_q.awready;
  assign wready     = s_q.wready;
  assign arready    = s_q.arready;
  assign bvalid     = s_q.bvalid;
  assign bresp      = s_q.bresp;
  assign rvalid     = s_q.rvalid;
  assign rdata      = s_q.rdata;
  assign rresp      = s_q.rresp;
  assign conv_start = s_q.conv_start;
  assign range_5v   = s_q.rng5;
  assign word_valid = s_q.word_valid;
  assign word_data  = s_q.word_data;
  assign word_entry = s_q.word_entry;
  assign word_last  = s_q.word_last;

  // words seen since the last tick, for the sweep checks
  logic [4:0] seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || s_q.conv_start) begin
      seen_q <= 5'h00;
    end else if (s_q.word_valid) begin
      seen_q <= seen_q + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sweep_start_s;
    s_q.fsm == ST_FETCH ##1 s_q.fsm == ST_SEND;
  endsequence

  sequence first_word_s;
    s_q.word_valid && s_q.word_entry == 5'h00;
  endsequence

  property tick_sweep_p;
    s_q.conv_start |-> sweep_start_s ##1 first_word_s;
  endproperty

  tick_starts_sweep_a: assert property (tick_sweep_p)
    else $error("tick did not start a sweep");

  sweep_word_count_a: assert property (word_valid && word_last |-> seen_q == s_q.len - 5'h01)
    else $error("sweep word count differs from list length");

  last_entry_a: assert property (word_valid |-> (word_last == (word_entry == s_q.len - 5'h01)))
    else $error("last flag on wrong entry");

  list_capacity_a: assert property (s_q.len <= NCH)
    else $error("list longer than capacity");

  dup_reject_a: assert property (
    mif.we |-> !s_q.used[mif.wdata] && mif.wdata < NCH)
    else $error("duplicate or unknown channel stored");

  period_window_a: assert property (s_q.period >= PMIN && s_q.period <= PER_MAX)
    else $error("pacing period outside rate window");

  ext_edge_tick_a: assert property (
    s_q.run && s_q.ext && s_q.fsm == ST_IDLE && s_q.xs[2] && !s_q.xs[1]
    |=> conv_start)
    else $error("external falling edge missed");

  ext_no_divide_a: assert property (
    s_q.run && s_q.ext && !(s_q.xs[2] && !s_q.xs[1]) && !$rose(s_q.run) |=> !conv_start)
    else $error("external mode ticked without an edge");

  start_paired_a: assert property ($rose(s_q.run) |-> pairs_ok(s_q.used) && conv_start)
    else $error("run started with unpaired halves or no trigger");

  range_pin_a: assert property (
    s_q.aw_got && s_q.w_got && !s_q.bvalid && {s_q.awaddr[7:2], 2'h0} == `A_CTRL && s_q.wstrb[0]
    |=> range_5v == $past(s_q.wdata[`B_RNG5]))
    else $error("range pin did not follow control write");

  int_rate_a: assert property (
    s_q.run && !s_q.ext && s_q.div == '0 && s_q.fsm == ST_IDLE |=> conv_start)
    else $error("internal pacing tick missed");
endmodule
`default_nettype wire

//--- test/ext_clock_source.sv
// external sample clock source that paces the converter from outside
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
  input  wire logic        aclk,
  input  wire logic        enable,
  input  wire logic [15:0] half,
  output logic             ext_clk
);
  logic [15:0] cnt_q;

  initial begin
    ext_clk = 1'b1;
    cnt_q = 16'h0000;
  end

  // stands high while disabled, so no stray falling edge reaches the device
  always @(posedge aclk) begin
    if (!enable) begin
      cnt_q <= 16'h0000;
      ext_clk <= 1'b1;
    end else if (cnt_q == half - 16'h0001) begin
      cnt_q <= 16'h0000;
      ext_clk <= ~ext_clk;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- test/simultaneous_scan_channel_list_bench.sv
// self-checking bench for the scan list controller
`timescale 1ns/1ps
`default_nettype none
`include "scan_defs.svh"
module simultaneous_scan_channel_list_bench;
  import scan_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } row_t;
  localparam int LIMIT = 30000;
  logic              aclk    = 1'b0;
  logic              aresetn = 1'b0;
  logic              awvalid = 1'b0;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  logic [7:0]        awaddr  = 8'h00;
  logic [7:0]        araddr  = 8'h00;
  logic [31:0]       wdata   = 32'h0;
  logic [3:0]        wstrb   = 4'hf;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [11:0][17:0] ain_raw = '0;
  logic [15:0]       din     = 16'ha5c3;
  logic [4:0][31:0]  pair_in = '0;
  logic              ext_clk;
  logic              ext_en  = 1'b0;
  logic              ext_d   = 1'b1;
  logic [15:0]       half    = 16'h0096;
  logic              conv_start, range_5v, word_valid, word_last;
  logic [15:0]       word_data;
  logic [4:0]        word_entry;
  int                n_fail    = 0;
  int                tests_run = 0;
  int                cyc       = 0;
  int                fall_cyc  = 0;
  int                lag       = 0;
  int                cs_q[$];
  logic [21:0]       w_q[$];
  logic [4:0]        lst[8]    = '{5'h0c, 5'h03, 5'h0e, 5'h0d, 5'h00, 5'h01, 5'h15, 5'h16};
  logic [15:0]       halves[2] = '{16'h0096, 16'h0028};
  row_t              rows[8]   = '{
    '{`A_PERIOD, 32'h0000_01bd, `RESP_OK}, '{`A_STAT, 32'h0, `RESP_OK},
    '{`A_INFO, 32'h0110_1701, `RESP_OK}, '{`A_LADD, 32'h0, `RESP_OK},
    '{`A_LCLR, 32'h0, `RESP_OK}, '{`A_CTRL, 32'h0, `RESP_OK},
    '{8'h18, 32'h0, `RESP_ERR}, '{8'hfc, 32'h0, `RESP_ERR}};

  scan_list_ctrl #(.LARGE(1'b1), .PER_MAX(32'd1000)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .ain_raw(ain_raw),
    .din(din), .ext_clk(ext_clk), .pair_in(pair_in), .conv_start(conv_start),
    .range_5v(range_5v), .word_valid(word_valid), .word_data(word_data),
    .word_entry(word_entry), .word_last(word_last));

  ext_clock_source src (.aclk(aclk), .enable(ext_en), .half(half), .ext_clk(ext_clk));

  always #5 aclk = ~aclk;

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (ext_d === 1'b1 && ext_clk === 1'b0) fall_cyc = cyc;
    ext_d = ext_clk;
    if (conv_start === 1'b1) begin
      cs_q.push_back(cyc);
      lag = cyc - fall_cyc;
    end
    if (word_valid === 1'b1) w_q.push_back({word_last, word_entry, word_data});
    if (cyc == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [21:0] got, input logic [21:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_p;
    bit w_p;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    do begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_reg({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ar_p;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    ar_p = 1'b1;
    do begin
      @(posedge aclk);
      if (ar_p && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_p = 1'b0;
      end
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_reg(rdata, ed);
    chk_reg({30'h0, rresp}, {30'h0, er});
  endtask

  // sel 0 counts sample ticks, sel 1 counts words; bounded so a hang cannot stall
  task automatic wait_cnt(input bit sel, input int n);
    int k;
    k = 0;
    while (((sel ? w_q.size() : cs_q.size()) < n) && k < 5000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 5000) begin
      n_fail++;
      $display("[ERR] %0t wait for sample stream timed out", $time);
    end
  endtask

  function automatic logic [15:0] expw(input logic [4:0] ch, input logic [15:0] dv);
    logic signed [17:0] r;
    logic [31:0]        p;
    if (ch < 5'h0c) begin
      r = ain_raw[ch];
      if (r > 18'sd32767) return 16'hffff;
      if (r < -18'sd32768) return 16'h0000;
      return r[15:0] ^ 16'h8000;
    end
    if (ch == 5'h0c) return dv;
    p = pair_in[(ch - 5'h0d) >> 1];
    return ch[0] ? p[15:0] : p[31:16];
  endfunction

  initial begin
    ain_raw[0] = 18'h30000;
    ain_raw[1] = 18'h09000;
    ain_raw[3] = 18'h01234;
    pair_in[0] = 32'h1111_2222;
    pair_in[4] = 32'hdead_beef;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].r);
    wr(8'h20, 32'h0, `RESP_ERR);
    // refused configurations
    wr(`A_CTRL, 32'h1, `RESP_OK);
    rd(`A_STAT, 32'h2, `RESP_OK);
    wr(`A_LCLR, 32'h0, `RESP_OK);
    wr(`A_LADD, 32'h3, `RESP_OK);
    wr(`A_LADD, 32'h3, `RESP_OK);
    wr(`A_LADD, 32'h17, `RESP_OK);
    rd(`A_LADD, 32'h1, `RESP_OK);
    rd(`A_STAT, 32'h2, `RESP_OK);
    wr(`A_LCLR, 32'h0, `RESP_OK);
    wr(`A_LADD, 32'hd, `RESP_OK);
    wr(`A_CTRL, 32'h1, `RESP_OK);
    rd(`A_STAT, 32'h2, `RESP_OK);
    wr(`A_LCLR, 32'h0, `RESP_OK);
    // host lists each channel once, halves paired
    foreach (lst[i]) wr(`A_LADD, {27'h0, lst[i]}, `RESP_OK);
    rd(`A_LADD, 32'h8, `RESP_OK);
    wr(`A_PERIOD, 32'd600, `RESP_OK);
    cs_q.delete();
    w_q.delete();
    wr(`A_CTRL, 32'h5, `RESP_OK);
    wait_cnt(1'b0, 1);
    din <= 16'h0f0f;
    wait_cnt(1'b1, 8);
    foreach (lst[i]) chk_word(w_q[i], {i == 7, 5'(i), expw(lst[i], 16'ha5c3)});
    chk_reg({31'h0, range_5v}, 32'h1);
    wait_cnt(1'b0, 3);
    chk_reg(cs_q[1] - cs_q[0], 32'd600);
    chk_reg(cs_q[2] - cs_q[1], 32'd600);
    wait_cnt(1'b1, 24);
    chk_word(w_q[16], {1'b0, 5'h00, 16'h0f0f});
    wr(`A_CTRL, 32'h1, `RESP_OK);
    repeat (2) @(posedge aclk);
    chk_reg({31'h0, range_5v}, 32'h0);
    wr(`A_CTRL, 32'h0, `RESP_OK);
    wr(`A_PERIOD, 32'd10, `RESP_OK);
    rd(`A_PERIOD, 32'd445, `RESP_OK);
    wr(`A_PERIOD, 32'd5000, `RESP_OK);
    rd(`A_PERIOD, 32'd1000, `RESP_OK);
    foreach (halves[j]) begin
      ext_en <= 1'b0;
      half <= halves[j];
      wr(`A_CTRL, 32'h0, `RESP_OK);
      repeat (40) @(posedge aclk);
      cs_q.delete();
      ext_en <= 1'b1;
      wr(`A_CTRL, 32'h3, `RESP_OK);
      wait_cnt(1'b0, 3);
      chk_reg(cs_q[2] - cs_q[1], {15'h0, halves[j], 1'b0});
      chk_reg(lag, 32'd3);
    end
    // mid-run reset: stream and bus back to idle, registers to defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_reg({24'h0, conv_start, word_valid, bvalid, rvalid, range_5v, awready, wready, arready},
            32'h7);
    rd(`A_STAT, 32'h0, `RESP_OK);
    rd(`A_PERIOD, 32'd445, `RESP_OK);
    wr(`A_CTRL, 32'h0, `RESP_OK);
    conclude();
  end
endmodule
`default_nettype wire
